/* core/wwds_pkg.sv */
// Package of the window watchdog supervisor: times, derived cycle counts, SPI frame layout and states.
// Assumes a 10 MHz core clock; the long counts are overridable at the top module.
package wwds_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;     // Core clock rate in hertz.
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000; // Core cycles per microsecond.
  localparam int unsigned WIN_LOW_MS    = 48;             // Window upper bound with the strap low.
  localparam int unsigned WIN_MID_MS    = 720;            // Window upper bound with the strap high.
  localparam int unsigned WIN_HIGH_MS   = 7200;           // Window upper bound with the strap open.
  localparam int unsigned RST_PULSE_US  = 1000;           // Low time of the watchdog reset outputs.
  localparam int unsigned FILTER_US     = 20;             // Glitch filter time of the trigger pin.
  localparam int unsigned WIN_LOW_CYC   = WIN_LOW_MS * 1000 * CYC_PER_US;  // Cycles, strap low.
  localparam int unsigned WIN_MID_CYC   = WIN_MID_MS * 1000 * CYC_PER_US;  // Cycles, strap high.
  localparam int unsigned WIN_HIGH_CYC  = WIN_HIGH_MS * 1000 * CYC_PER_US; // Cycles, strap open.
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * CYC_PER_US;       // Cycles of reset pulse.
  localparam int unsigned FILTER_CYC    = FILTER_US * CYC_PER_US;          // Cycles of filter time.
  localparam int unsigned TIMER_W       = 27;             // Timer width, holds the longest window.
  localparam int unsigned STRAP_SETTLE  = 6;              // Cycles after reset before straps latch, past sync delay.

  // ----------------------------------------------------------------------
  // Strap codes of the window-select pin comparator
  // ----------------------------------------------------------------------
  localparam logic [1:0] WSEL_LOW  = 2'h0;                // Pin tied low.
  localparam logic [1:0] WSEL_HIGH = 2'h1;                // Pin tied high.

  // ----------------------------------------------------------------------
  // SPI frame layout and the kick register
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;                // Bits of one SPI frame.
  localparam logic [6:0]  KICK_ADDR  = 7'h15;             // Offset of kick_register.
  localparam logic [7:0]  KICK_VALUE = 8'hFF;             // Value that services the watchdog.

  // One SPI frame, most significant bit first on the wire.
  typedef struct packed {
    logic       wr;                                       // High for a register write.
    logic [6:0] addr;                                     // Register offset.
    logic [7:0] data;                                     // Write data.
  } wwds_frame_s;

  // Watchdog sequencer states.
  typedef enum logic [1:0] {
    ST_WAIT,                                              // Timer stopped until the first trigger.
    ST_CLOSED,                                            // Closed half of the window.
    ST_OPEN,                                              // Open half of the window.
    ST_PULSE                                              // Reset output held low.
  } wwds_state_e;

endpackage : wwds_pkg

/* core/wwds_top.sv */
// Window watchdog supervisor: strap sampling, trigger filter, SPI kick receiver and window sequencer.
// Assumes pads resolve the three-level window strap into a two-bit code and give a supply-good level.
// Operation
// R1: Control-select low at power up: pin control.
// R2: Control-select high (pull-up) at power up: SPI.
// R3: Pin mode window length follows window strap.
// R4: Trigger pin transitions service the open window.
// R5: Pin mode fault drives watchdog reset low.
// R6: SPI write FFh to 15h services.
// R7: Processor services within the window.
// R8: SPI mode faults use the supervisor reset.
// R9: Timer stopped until the first trigger.
// R10: Supervisor reset follows supply above undervoltage.
// R11: Enable, wake or bus activity leave sleep.
// R12: SPI clock no faster than 5 MHz.
// R13: Chip select high 500 ns between accesses.
// R14: Strap picks 48 ms, 720 ms, 7.2 s; halves.
// R15: Reset output low for fixed time, released.
// R16: Either trigger edge counts after glitch filter.
// R17: Early trigger or missing trigger is fault.
`timescale 1ns/1ps
module wwds_top #(
  parameter int unsigned WIN_LOW_CYC   = wwds_pkg::WIN_LOW_CYC,   // Window cycles, strap low.
  parameter int unsigned WIN_MID_CYC   = wwds_pkg::WIN_MID_CYC,   // Window cycles, strap high.
  parameter int unsigned WIN_HIGH_CYC  = wwds_pkg::WIN_HIGH_CYC,  // Window cycles, strap open.
  parameter int unsigned RST_PULSE_CYC = wwds_pkg::RST_PULSE_CYC, // Reset pulse cycles.
  parameter int unsigned FILTER_CYC    = wwds_pkg::FILTER_CYC     // Trigger filter cycles.
) (
  input  wire logic       clk,                  // Core clock.
  input  wire logic       arst_n,               // Power-up reset, asynchronous, active low.
  input  wire logic       spi_sclk,             // SPI serial clock, the link clock.
  input  wire logic       control_select_pin,   // Strap at power up, SPI chip select (low active) after.
  input  wire logic       service_trigger_in,   // Trigger pin in pin mode, serial data in SPI mode.
  input  wire logic [1:0] window_select_in,     // Strap code: 0 low, 1 high, 2 or 3 open.
  input  wire logic       supply_ok_in,         // High while the supply is above its threshold.
  input  wire logic       enable_wake_in,       // Enable pin level.
  input  wire logic       local_wake_in,        // Local wake pin level.
  input  wire logic       bus_wake_in,          // Bus activity detector level.
  output logic            watchdog_reset_out,   // Pin mode watchdog reset, active low.
  output logic            supervisor_reset_out, // Supervisor reset, active low.
  output logic            spi_mode_out,         // High once SPI control is latched.
  output logic            leave_sleep_out       // High while any wake source is active.
);

  // ----------------------------------------------------------------------
  // SPI receiver on the link clock
  // ----------------------------------------------------------------------
  logic [3:0]          bit_cnt_reg;             // Bits received in the current frame.
  logic [14:0]         shift_reg;               // Bits received so far.
  wwds_pkg::wwds_frame_s frame_reg;             // Last complete frame.
  logic                frame_tgl_reg;           // Toggles once per complete frame.
  wire                 frame_last = (bit_cnt_reg == 4'(wwds_pkg::FRAME_BITS - 1)); // Final bit now.

  // The bit counter is cleared by chip select itself, so a cut frame never leaves a stale count.
  always_ff @(posedge spi_sclk or posedge control_select_pin) begin
    if (control_select_pin) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Shift data in, and on the final bit hold the frame and toggle the event flag.
  always_ff @(posedge spi_sclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg     <= 15'h0000;
      frame_reg     <= '0;
      frame_tgl_reg <= 1'b0;
    end else begin
      shift_reg <= {shift_reg[13:0], service_trigger_in};
      if (frame_last) begin
        frame_reg     <= {shift_reg, service_trigger_in};
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Three-flop synchronisers for pins and the frame toggle
  // ----------------------------------------------------------------------
  localparam int NSYNC = 9;                     // Number of synchronised bits.
  wire  [NSYNC-1:0] async_in = {window_select_in, frame_tgl_reg, bus_wake_in, local_wake_in,
                                enable_wake_in, supply_ok_in, control_select_pin, service_trigger_in};
  logic [NSYNC-1:0] s1_reg;                     // First stage, read only by the second.
  logic [NSYNC-1:0] s2_reg;                     // Second stage.
  logic [NSYNC-1:0] s3_reg;                     // Third stage.
  logic [NSYNC-1:0] stable_reg;                 // Accepted level once stages two and three agree.
  wire  [NSYNC-1:0] stable_next = (s2_reg & s3_reg) | (stable_reg & (s2_reg ^ s3_reg));

  // Shift the pins through three flops and accept a change when two stages agree.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      stable_reg <= '0;
    end else begin
      s1_reg     <= async_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  wire       trig_s    = stable_reg[0];         // Filtered-to-be trigger pin level.
  wire       csel_s    = stable_reg[1];         // Control-select level.
  wire       supply_s  = stable_reg[2];         // Supply good level.
  wire       tgl_s     = stable_reg[6];         // Frame toggle in core domain.
  wire [1:0] wsel_s    = stable_reg[8:7];       // Window strap code.

  // Any wake source ends sleep.
  assign leave_sleep_out = |stable_reg[5:3];    // R11

  // ----------------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------------
  logic [2:0] settle_reg;                       // Counts cycles until straps are settled.
  logic       strap_done_reg;                   // High once straps are latched.
  logic       spi_mode_reg;                     // Latched control mode, high for SPI.
  logic [1:0] wsel_reg;                         // Latched window strap code.
  wire        settle_end = (settle_reg == 3'(wwds_pkg::STRAP_SETTLE - 1));

  // Latch control mode and window strap once, a few cycles after the reset lifts.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_reg     <= 3'h0;
      strap_done_reg <= 1'b0;
      spi_mode_reg   <= 1'b0;
      wsel_reg       <= 2'h0;
    end else if (!strap_done_reg) begin
      settle_reg <= settle_reg + 3'h1;
      if (settle_end) begin
        strap_done_reg <= 1'b1;
        spi_mode_reg   <= csel_s;               // R1 R2
        wsel_reg       <= wsel_s;               // R3
      end
    end
  end
  assign spi_mode_out = spi_mode_reg;

  // ----------------------------------------------------------------------
  // Trigger pin glitch filter and kick sources
  // ----------------------------------------------------------------------
  logic                trig_f_reg;              // Filtered trigger level.
  logic [15:0]         filt_cnt_reg;            // Cycles the new level has held.
  logic                tgl_seen_reg;            // Frame toggle already handled.
  wire                 trig_diff = (trig_s != trig_f_reg);
  wire                 filt_done = trig_diff && (filt_cnt_reg == 16'(FILTER_CYC - 1));
  wire                 frame_new = (tgl_s != tgl_seen_reg);
  wire                 pin_kick  = strap_done_reg && !spi_mode_reg && filt_done;
  wire                 spi_kick  = strap_done_reg && spi_mode_reg && frame_new && frame_reg.wr &&
                                   (frame_reg.addr == wwds_pkg::KICK_ADDR) &&
                                   (frame_reg.data == wwds_pkg::KICK_VALUE);
  wire                 kick      = pin_kick || spi_kick;

  // A level that holds for the filter time becomes the new trigger level; either edge counts.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_f_reg   <= 1'b0;
      filt_cnt_reg <= 16'h0000;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_seen_reg <= tgl_s;
      if (!trig_diff || filt_done) begin
        filt_cnt_reg <= 16'h0000;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 16'h0001;
      end
      // Until the straps are latched the filter tracks the pin, so a pin resting high is no kick.
      if (filt_done || !strap_done_reg) begin
        trig_f_reg <= trig_s;                   // R16
      end
    end
  end

  // ----------------------------------------------------------------------
  // Window sequencer
  // ----------------------------------------------------------------------
  localparam int TW = wwds_pkg::TIMER_W;        // Timer width.
  wwds_pkg::wwds_state_e state_reg;             // Current sequencer state.
  wwds_pkg::wwds_state_e state_next;            // Next sequencer state.
  logic [TW-1:0]         timer_reg;             // Cycles spent in the current state.
  logic [TW-1:0]         timer_next;            // Next timer value.
  wire  [TW-1:0] win_full = (wsel_reg == wwds_pkg::WSEL_LOW)  ? TW'(WIN_LOW_CYC) :
                            (wsel_reg == wwds_pkg::WSEL_HIGH) ? TW'(WIN_MID_CYC) :
                                                                TW'(WIN_HIGH_CYC); // R14
  wire  [TW-1:0] win_half  = win_full >> 1;     // Closed and open halves are equal.
  wire           half_end  = (timer_reg == win_half - TW'(1));
  wire           pulse_end = (timer_reg == TW'(RST_PULSE_CYC - 1));

  // Choose the next state and timer from the kick and the elapsed time.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg + TW'(1);
    unique case (state_reg)
      wwds_pkg::ST_WAIT: begin
        timer_next = '0;                        // R9
        if (kick) begin
          state_next = wwds_pkg::ST_CLOSED;
        end
      end
      wwds_pkg::ST_CLOSED: begin
        if (kick) begin
          state_next = wwds_pkg::ST_PULSE;      // R17
          timer_next = '0;
        end else if (half_end) begin
          state_next = wwds_pkg::ST_OPEN;       // R3
          timer_next = '0;
        end
      end
      wwds_pkg::ST_OPEN: begin
        if (kick) begin
          state_next = wwds_pkg::ST_CLOSED;     // R4 R6
          timer_next = '0;
        end else if (half_end) begin
          state_next = wwds_pkg::ST_PULSE;      // R17
          timer_next = '0;
        end
      end
      wwds_pkg::ST_PULSE: begin
        if (pulse_end) begin
          state_next = wwds_pkg::ST_WAIT;       // R15
          timer_next = '0;
        end
      end
    endcase
  end

  // Hold the sequencer state and timer.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= wwds_pkg::ST_WAIT;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // Drive the reset outputs from registers; the pin in use depends on the control mode.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_reset_out   <= 1'b1;
      supervisor_reset_out <= 1'b0;
    end else begin
      watchdog_reset_out   <= !(!spi_mode_reg && state_next == wwds_pkg::ST_PULSE);          // R5
      supervisor_reset_out <= supply_s && !(spi_mode_reg && state_next == wwds_pkg::ST_PULSE); // R8 R10
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_mode_strap_latch: assert property ( // R1 R2
    $rose(strap_done_reg) |-> spi_mode_reg == $past(csel_s)) else $error("Control mode not latched from strap.");
  a_stopped_until_kick: assert property ( // R9
    (state_reg == wwds_pkg::ST_WAIT && !kick) |=> state_reg == wwds_pkg::ST_WAIT && timer_reg == '0)
    else $error("Timer left stop without a trigger.");
  a_closed_to_open: assert property ( // R3
    (state_reg == wwds_pkg::ST_CLOSED && half_end && !kick) |=> state_reg == wwds_pkg::ST_OPEN)
    else $error("Closed window did not end at its half.");
  a_open_kick_restart: assert property ( // R4
    (state_reg == wwds_pkg::ST_OPEN && kick) |=> state_reg == wwds_pkg::ST_CLOSED && timer_reg == '0)
    else $error("Open window trigger did not restart.");
  a_early_kick_fault: assert property ( // R17
    (state_reg == wwds_pkg::ST_CLOSED && kick) |=>
      state_reg == wwds_pkg::ST_PULSE ##1 (!watchdog_reset_out || spi_mode_reg))
    else $error("Early trigger was not a fault.");
  a_pin_reset_low: assert property ( // R5
    (!spi_mode_reg && state_reg == wwds_pkg::ST_PULSE) |->
      !watchdog_reset_out && ($past(state_reg) == wwds_pkg::ST_PULSE || $fell(watchdog_reset_out)))
    else $error("Pin mode fault did not drive reset low.");
  a_spi_uses_sup: assert property ( // R8
    (spi_mode_reg && state_reg == wwds_pkg::ST_PULSE) |-> !supervisor_reset_out && watchdog_reset_out)
    else $error("SPI mode fault used the wrong output.");
  a_undervolt_reset: assert property ( // R10
    (!$past(supply_s)) |-> !supervisor_reset_out) else $error("Supervisor reset high under undervoltage.");
  a_pulse_length: assert property ( // R15
    (state_reg == wwds_pkg::ST_PULSE && pulse_end) |=> state_reg == wwds_pkg::ST_WAIT)
    else $error("Reset pulse did not end on time.");
  a_pulse_bound: assert property ( // R15
    (state_reg == wwds_pkg::ST_PULSE) |-> timer_reg < TW'(RST_PULSE_CYC)) else $error("Reset pulse too long.");
  a_filter_time: assert property ( // R16
    pin_kick |-> trig_diff && filt_cnt_reg == 16'(FILTER_CYC - 1)) else $error("Trigger accepted before filter time.");
  a_spi_kick_value: assert property ( // R6
    spi_kick |-> frame_reg.data == 8'hFF && frame_reg.addr == 7'h15) else $error("Kick taken from wrong frame.");

endmodule : wwds_top

/* tb/wwds_host_model.sv */
// Host model: the supervised processor that drives the trigger pin or the SPI frames.
// Assumes the core clock only for pacing; the SPI clock stands still outside frames.
`timescale 1ns/1ps
module wwds_host_model (
  input  wire logic clk,    // Core clock, used for pacing only.
  output logic      cs_pin, // Strap at power up, chip select afterwards.
  output logic      sclk,   // SPI clock, low between frames.
  output logic      trig    // Trigger level in pin mode, serial data in SPI mode.
);
  localparam int HALF_NS = 120; // Half period of the SPI clock, about 4.2 MHz, below 5 MHz.

  // Idle levels before anything is asked of the model.
  initial begin
    cs_pin = 1'b1;
    sclk   = 1'b0;
    trig   = 1'b0;
  end

  // Sets the level of the control-select pin while the device samples it.
  task automatic strap(input logic v);
    cs_pin = v;
  endtask : strap

  // One level change of the trigger pin is one service event.
  task automatic toggle();
    @(negedge clk);
    trig = ~trig;
  endtask : toggle

  // A two-cycle pulse that passes the synchroniser but that the glitch filter must reject.
  task automatic glitch();
    @(negedge clk);
    trig = ~trig;
    repeat (2) @(negedge clk);
    trig = ~trig;
  endtask : glitch

  // Sends one 16-bit frame, most significant bit first, data changed while the clock is low.
  task automatic frame(input logic [15:0] word);
    @(negedge clk);
    cs_pin = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      trig = word[i];
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    cs_pin = 1'b1;
    // The released data line shows the inverse of its last bit so no stale value passes.
    trig = ~word[0];
    #500;
  endtask : frame
endmodule : wwds_host_model

/* tb/wwds_top_tb.sv */
// Testbench of the window watchdog supervisor: each test task runs one scenario and judges it.
// Assumes shortened window, pulse and filter counts set at the instance below.
`timescale 1ns/1ps
module wwds_top_tb;
  localparam int WIN_LOW   = 200; // Shortened window, strap low.
  localparam int WIN_MID   = 400; // Shortened window, strap high.
  localparam int WIN_HIGH  = 800; // Shortened window, strap open.
  localparam int RST_PULSE = 20;  // Shortened reset pulse.

  logic       clk;          // Core clock.
  logic       arst_n;       // Power-up reset.
  logic       cs_pin;       // Control-select pin from the host.
  logic       sclk;         // SPI clock from the host.
  logic       trig;         // Trigger or serial data from the host.
  logic [1:0] wsel;         // Window strap code.
  logic       supply_ok;    // Supply above threshold.
  logic [2:0] wake;         // Enable, local and bus wake sources.
  logic       wd_rst_n;     // Watchdog reset output.
  logic       sup_rst_n;    // Supervisor reset output.
  logic       spi_mode;     // SPI control latched.
  logic       leave_sleep;  // Wake request.
  int         n_errors;     // Mismatches seen.
  int         n_tests;      // Comparisons made.

  // Free-running 10 MHz core clock.
  always #50 clk = ~clk;

  wwds_host_model u_wwds_host_model (.clk(clk), .cs_pin(cs_pin), .sclk(sclk), .trig(trig));

  wwds_top #(.WIN_LOW_CYC(WIN_LOW), .WIN_MID_CYC(WIN_MID), .WIN_HIGH_CYC(WIN_HIGH),
             .RST_PULSE_CYC(RST_PULSE), .FILTER_CYC(4)) u_wwds_top (
    .clk(clk), .arst_n(arst_n), .spi_sclk(sclk), .control_select_pin(cs_pin),
    .service_trigger_in(trig), .window_select_in(wsel), .supply_ok_in(supply_ok),
    .enable_wake_in(wake[0]), .local_wake_in(wake[1]), .bus_wake_in(wake[2]),
    .watchdog_reset_out(wd_rst_n), .supervisor_reset_out(sup_rst_n),
    .spi_mode_out(spi_mode), .leave_sleep_out(leave_sleep));

  // Counts and reports one comparison.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Counts cycles until the chosen reset output reaches a level, at most max cycles.
  task automatic wait_lvl(input logic sup, input logic v, input int max, output int n);
    n = 0;
    while (n < max && (sup ? sup_rst_n : wd_rst_n) !== v) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lvl

  // Power-up reset with the given straps, then the latched mode is checked.
  task automatic do_reset(input logic spi, input logic [1:0] code);
    @(negedge clk);
    arst_n = 1'b0;
    wsel   = code;
    u_wwds_host_model.strap(spi);
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (12) @(negedge clk);
    check("spi_mode_out", spi_mode, spi);
  endtask : do_reset

  // Strap codes 0, 1 and 2: timer idle until the first trigger, then a fault after the full window.
  task automatic test_windows();
    int n;
    int win [3] = '{WIN_LOW, WIN_MID, WIN_HIGH};
    for (int k = 0; k < 3; k++) begin
      do_reset(1'b0, k[1:0]);
      wait_lvl(1'b0, 1'b0, 300, n);
      check("idle before trigger", n, 300);
      u_wwds_host_model.toggle();
      wait_lvl(1'b0, 1'b0, win[k] + 30, n);
      check("missing trigger fault time", n >= win[k] && n <= win[k] + 16, 1);
      check("supervisor reset in pin mode", sup_rst_n, 1'b1);
    end
    $display("test_windows done");
  endtask : test_windows

  // A glitch is ignored; triggers in the open half keep the output high.
  task automatic test_timely();
    int n;
    do_reset(1'b0, 2'h0);
    u_wwds_host_model.glitch();
    wait_lvl(1'b0, 1'b0, WIN_LOW + 50, n);
    check("glitch ignored", n, WIN_LOW + 50);
    u_wwds_host_model.toggle();
    repeat (3) begin
      wait_lvl(1'b0, 1'b0, 150, n);
      check("open window trigger", n, 150);
      u_wwds_host_model.toggle();
    end
    $display("test_timely done");
  endtask : test_timely

  // A trigger in the closed half faults; the pulse has its fixed length.
  task automatic test_early();
    int n;
    do_reset(1'b0, 2'h0);
    u_wwds_host_model.toggle();
    wait_lvl(1'b0, 1'b0, 40, n);
    u_wwds_host_model.toggle();
    wait_lvl(1'b0, 1'b0, 30, n);
    check("early trigger fault", n < 30, 1);
    wait_lvl(1'b0, 1'b1, 40, n);
    check("reset pulse length", n >= RST_PULSE - 1 && n <= RST_PULSE + 1, 1);
    $display("test_early done");
  endtask : test_early

  // Only a write of the kick value to the kick register services; faults use the supervisor reset.
  task automatic test_spi();
    int n;
    wwds_pkg::wwds_frame_s good;
    wwds_pkg::wwds_frame_s bad [3];
    good = '{wr: 1'b1, addr: wwds_pkg::KICK_ADDR, data: wwds_pkg::KICK_VALUE};
    bad[0] = good;
    bad[0].addr = 7'h14;
    bad[1] = good;
    bad[1].data = 8'hFE;
    bad[2] = good;
    bad[2].wr = 1'b0;
    // The longer strap-high window keeps the last frame well inside the closed half.
    for (int k = 0; k < 3; k++) begin
      do_reset(1'b1, 2'h1);
      u_wwds_host_model.frame(good);
      u_wwds_host_model.frame(bad[k]);
      wait_lvl(1'b1, 1'b0, 10, n);
      check("foreign frame ignored", n, 10);
    end
    u_wwds_host_model.frame(good);
    wait_lvl(1'b1, 1'b0, 20, n);
    check("spi early fault", n < 20, 1);
    check("pin reset idle in spi mode", wd_rst_n, 1'b1);
    $display("test_spi done");
  endtask : test_spi

  // Supervisor reset follows the supply; each wake source requests leaving sleep.
  task automatic test_supply_wake();
    int n;
    do_reset(1'b0, 2'h0);
    @(negedge clk);
    supply_ok = 1'b0;
    wait_lvl(1'b1, 1'b0, 10, n);
    check("undervoltage reset", n < 10, 1);
    supply_ok = 1'b1;
    wait_lvl(1'b1, 1'b1, 10, n);
    check("supply good release", n < 10, 1);
    for (int k = 0; k < 3; k++) begin
      wake = 3'h1 << k;
      repeat (8) @(negedge clk);
      check("wake source", leave_sleep, 1'b1);
      wake = 3'h0;
      repeat (8) @(negedge clk);
      check("no wake source", leave_sleep, 1'b0);
    end
    $display("test_supply_wake done");
  endtask : test_supply_wake

  // Main sequence.
  initial begin
    clk       = 1'b0;
    arst_n    = 1'b0;
    wsel      = 2'h0;
    supply_ok = 1'b1;
    wake      = 3'h0;
    n_errors  = 0;
    n_tests   = 0;
    test_windows();
    test_timely();
    test_early();
    test_spi();
    test_supply_wake();
    finish_test();
  end

  // Watchdog: the scenarios need well under a millisecond of simulated time.
  initial begin
    #3_000_000;
    n_errors++;
    finish_test();
  end
endmodule : wwds_top_tb
